// ---- reply_map.vh ----
`ifndef REPLY_MAP_VH
`define REPLY_MAP_VH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_LBA_LO    8'h00
`define OFS_LBA_HI    8'h04
`define OFS_BLK_LEN   8'h08
`define OFS_PROT      8'h0c
`define OFS_HIST_WR   8'h10
`define OFS_HIST_CLR  8'h14
`define OFS_IRQ_STAT  8'h18
`define OFS_IRQ_MASK  8'h1c
`define OFS_STATE     8'h20
// ****************************************************************
// field positions and reset values
// ****************************************************************
`define PROT_EN_BIT   0
`define PROT_TYPE_LSB 1
`define PROT_EXP_LSB  8
`define RST_BLK_LEN   32'h0000_0200
`define IRQ_DONE_BIT  0
`define IRQ_CHK_BIT   1
// ****************************************************************
// command codes and history buffer ids
// ****************************************************************
`define OP_CAP10      8'h25
`define OP_CAP16      8'h9e
`define SA_CAP16      5'h10
`define OP_RDBUF      8'h3c
`define MODE_HIST     5'h1c
`define ID_DIR_LAST   8'h03
`define ID_HIST       8'h10
`define ID_HIST_LAST  8'hef
`define ID_CLR        8'hfe
`define ID_CLR_REL    8'hff
// ****************************************************************
// reply sizes and sense codes
// ****************************************************************
`define DIR_HDR_LEN   16'd32
`define DIR_ENTRIES   16'd5
`define CAP10_LEN     16'd8
`define CAP16_LEN     16'd32
`define KEY_ILLEGAL   4'h5
`define ASC_BAD_FIELD 16'h2400
`define ASC_BAD_OP    16'h2000
`define ASC_IN_PROG   16'h0016
`endif

// ---- capacity_history_reply.v ----
// Function
// - one directory entry per supported id
// - 32-byte header: vendor, version, length
// - entry: id, zeros, big-endian max count
// - max count is bound, fewer may exist
// - history read returns snapshot from offset
// - unsupported id gives invalid field error
// - unsupported offset gives invalid field error
// - history never exceeds reported max count
// - short capacity opcode 25h, ten bytes
// - short reply: lba then block length
// - block length excludes protection bytes
// - long capacity 9eh/10h, allocation length
// - long command handled like short one
// - long reply: lba, length, zero tail
// - byte 12 reports protection type
// - byte 13 low nibble: block exponent
// - ids 00h-03h directory, 10h-efh history; the code accepts only 10h
// - foreign nexus while snapshot: in progress
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`include "reply_map.vh"
module capacity_history_reply #(
  parameter HIST_DEPTH = 64,                 // history bytes held
  parameter NEXUS_W    = 8,                  // nexus id width
  parameter VENDOR_ID  = 64'h5645_4e44_4f52_5820, // arbitrary value
  parameter VERSION    = 8'h01               // arbitrary value
) (
  input  wire               ref_clk,
  input  wire               rst_n,
  input  wire               ce,
  input  wire               cmd_valid,
  input  wire [127:0]       cmd_cdb,
  input  wire [NEXUS_W-1:0] cmd_nexus,
  output wire               cmd_ready,
  output reg                din_valid_q,
  output reg  [7:0]         din_data_q,
  output reg                din_last_q,
  input  wire               din_ready,
  output reg                done_q,
  output reg                chk_cond_q,
  output reg  [3:0]         sense_key_q,
  output reg  [15:0]        sense_asc_q,
  input  wire [7:0]         reg_addr,
  input  wire [31:0]        reg_wdata,
  input  wire               reg_wr,
  input  wire               reg_rd,
  output reg  [31:0]        reg_rdata_q,
  output wire               irq
);
  // ****************************************************************
  // state codes and reply kinds
  // ****************************************************************
  localparam ST_IDLE = 2'd0;
  localparam ST_SEND = 2'd1;
  localparam ST_END  = 2'd2;
  localparam K_CAP10 = 2'd0;
  localparam K_CAP16 = 2'd1;
  localparam K_DIR   = 2'd2;
  localparam K_HIST  = 2'd3;
  localparam [15:0] DIR_LEN = `DIR_HDR_LEN + 16'd8 * `DIR_ENTRIES;
  localparam [15:0] HIST_MAX = HIST_DEPTH[15:0];       // history cap
  localparam [15:0] DIR_LEN_M31 = DIR_LEN - 16'd31;    // length field

  // ****************************************************************
  // storage
  // ****************************************************************
  reg [63:0]        max_lba_q;     // highest logical block address
  reg [31:0]        blk_len_q;     // user bytes per block
  reg               prot_en_q;     // protection enable
  reg [2:0]         prot_type_q;   // protection type
  reg [3:0]         blk_exp_q;     // blocks per physical exponent
  reg [7:0]         hist_mem [0:HIST_DEPTH-1]; // history bytes
  reg [15:0]        hist_len_q;    // bytes held in history
  reg               snap_q;        // snapshot exists
  reg               nexus_v_q;     // history nexus established
  reg [NEXUS_W-1:0] nexus_q;       // owning nexus
  reg [1:0]         irq_stat_q;    // sticky events
  reg [1:0]         irq_mask_q;    // event enables
  reg [1:0]         state_q;       // reply sequencer
  reg [1:0]         kind_q;        // reply being built
  reg [15:0]        ofs_q;         // history start offset
  reg [15:0]        idx_q;         // next reply byte
  reg [15:0]        len_q;         // bytes to send
  reg               err_q;         // ending with check condition
  reg [15:0]        asc_q;         // pending sense code
  integer           i;

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // pick one byte of the command block, byte 0 first
  function [7:0] cdb_byte;
    input [127:0] cdb;
    input [3:0]   n;
    begin
      cdb_byte = cdb[127 - 8*n -: 8];
    end
  endfunction

  // smaller of allocation and reply length
  function [15:0] clip;
    input [31:0] alloc;
    input [15:0] full;
    begin
      clip = (alloc < {16'h0000, full}) ? alloc[15:0] : full;
    end
  endfunction

  // ****************************************************************
  // command decode
  // ****************************************************************
  wire [7:0]  op     = cdb_byte(cmd_cdb, 4'd0);
  wire [7:0]  b1     = cdb_byte(cmd_cdb, 4'd1);
  wire [7:0]  buf_id = cdb_byte(cmd_cdb, 4'd2);
  wire [23:0] rb_ofs = cmd_cdb[103:80];
  wire [23:0] rb_all = cmd_cdb[79:56];
  wire [31:0] c16_all = cmd_cdb[47:16];
  wire        is_dir  = buf_id <= `ID_DIR_LAST;
  wire        is_hist = buf_id == `ID_HIST;
  wire        is_clr  = (buf_id == `ID_CLR) || (buf_id == `ID_CLR_REL);
  // ids 02h and 03h are free of the nexus constraint
  wire        unconstr = (buf_id == 8'h02) || (buf_id == 8'h03);
  wire        foreign  = nexus_v_q && (cmd_nexus != nexus_q);
  wire        take     = ce && cmd_valid && (state_q == ST_IDLE);
  assign cmd_ready = (state_q == ST_IDLE);

  // ****************************************************************
  // reply byte builder
  // ****************************************************************
  reg  [7:0]  rb;                  // byte at idx_q
  reg  [15:0] rel;                 // offset into directory list
  reg  [7:0]  ent_id;              // id of directory entry
  reg  [31:0] ent_max;             // max count of that entry
  wire [31:0] lba10 = (|max_lba_q[63:32]) ? 32'hffff_ffff : max_lba_q[31:0];
  wire [15:0] hidx  = ofs_q + idx_q;
  always @* begin
    rb      = 8'h00;
    rel     = idx_q - `DIR_HDR_LEN;
    ent_id  = 8'h00;
    ent_max = 32'h0;
    case (kind_q)
      K_CAP10: begin
        if (idx_q < 16'd4) begin
          rb = lba10[31 - 8*idx_q[1:0] -: 8];
        end else begin
          rb = blk_len_q[31 - 8*idx_q[1:0] -: 8];
        end
      end
      K_CAP16: begin
        if (idx_q < 16'd8) begin
          rb = max_lba_q[63 - 8*idx_q[2:0] -: 8];
        end else if (idx_q < 16'd12) begin
          rb = blk_len_q[31 - 8*idx_q[1:0] -: 8];
        end else if (idx_q == 16'd12) begin
          rb = {4'h0, prot_type_q, prot_en_q};
        end else if (idx_q == 16'd13) begin
          rb = {4'h0, blk_exp_q};
        end
      end
      K_DIR: begin
        if (idx_q < 16'd8) begin
          rb = VENDOR_ID[63 - 8*idx_q[2:0] -: 8];
        end else if (idx_q == 16'd8) begin
          rb = VERSION;
        end else if (idx_q == 16'd9) begin
          rb = 8'h01;              // history_clear_supported
        end else if (idx_q[15:1] == 15'd15) begin
          // length field, bytes 30 and 31
          rb = idx_q[0] ? DIR_LEN_M31[7:0] : DIR_LEN_M31[15:8];
        end else if (idx_q >= `DIR_HDR_LEN) begin
          if (rel[15:3] < 13'd4) begin
            ent_id  = {5'h00, rel[5:3]};
            ent_max = {16'h0, DIR_LEN};
          end else begin
            ent_id  = `ID_HIST;
            // bound only; fewer may be held
            ent_max = {16'h0, HIST_MAX};
          end
          if (rel[2:0] == 3'd0) begin
            rb = ent_id;
          end else if (rel[2]) begin
            rb = ent_max[31 - 8*rel[1:0] -: 8];
          end
        end
      end
      default: begin
        rb = hist_mem[hidx[5:0]];
      end
    endcase
  end

  // ****************************************************************
  // command acceptance and reply sequencer
  // ****************************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      kind_q      <= K_CAP10;
      ofs_q       <= 16'h0;
      idx_q       <= 16'h0;
      len_q       <= 16'h0;
      err_q       <= 1'b0;
      asc_q       <= 16'h0;
      snap_q      <= 1'b0;
      nexus_v_q   <= 1'b0;
      nexus_q     <= {NEXUS_W{1'b0}};
      din_valid_q <= 1'b0;
      din_data_q  <= 8'h00;
      din_last_q  <= 1'b0;
      done_q      <= 1'b0;
      chk_cond_q  <= 1'b0;
      sense_key_q <= 4'h0;
      sense_asc_q <= 16'h0;
    end else if (ce) begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            idx_q   <= 16'h0;
            err_q   <= 1'b0;
            state_q <= ST_SEND;
            if (op == `OP_CAP10) begin
              kind_q <= K_CAP10;
              len_q  <= `CAP10_LEN;
            end else if (op == `OP_CAP16 && b1[4:0] == `SA_CAP16) begin
              kind_q <= K_CAP16;
              len_q  <= clip(c16_all, `CAP16_LEN);
            end else if (op == `OP_RDBUF && b1[4:0] == `MODE_HIST) begin
              len_q <= 16'h0;
              if (!unconstr && foreign && snap_q) begin
                err_q <= 1'b1;
                asc_q <= `ASC_IN_PROG;
              // directory ids, offset must be zero
              end else if (is_dir) begin
                if (rb_ofs != 24'h0) begin
                  err_q <= 1'b1;
                  asc_q <= `ASC_BAD_FIELD;
                end else begin
                  kind_q <= K_DIR;
                  len_q  <= clip({8'h00, rb_all}, DIR_LEN);
                  snap_q <= snap_q | buf_id[0]; // 01h, 03h freeze
                  if (buf_id[1]) begin
                    nexus_v_q <= 1'b1;
                    nexus_q   <= cmd_nexus;
                  end
                end
              end else if (is_hist) begin
                // offset past held data or above ffffh
                if (rb_ofs > {8'h00, hist_len_q} ||
                    rb_ofs[23:16] != 8'h00) begin
                  err_q <= 1'b1;
                  asc_q <= `ASC_BAD_FIELD;
                end else begin
                  kind_q <= K_HIST;
                  ofs_q  <= rb_ofs[15:0];
                  len_q  <= clip({8'h00, rb_all},
                                 hist_len_q - rb_ofs[15:0]);
                end
              end else if (is_clr) begin
                nexus_v_q <= 1'b0;
                snap_q <= snap_q & ~buf_id[0]; // ffh releases snapshot
              end else begin
                err_q <= 1'b1;
                asc_q <= `ASC_BAD_FIELD;
              end
            end else begin
              len_q <= 16'h0;
              err_q <= 1'b1;
              asc_q <= `ASC_BAD_OP;
            end
          end
        end
        ST_SEND: begin
          // load next byte when slot free
          if (!din_valid_q || din_ready) begin
            if (idx_q < len_q && !err_q) begin
              din_valid_q <= 1'b1;
              din_data_q  <= rb;
              din_last_q  <= (idx_q == len_q - 16'd1);
              idx_q       <= idx_q + 16'd1;
            end else begin
              din_valid_q <= 1'b0;
              din_last_q  <= 1'b0;
              state_q     <= ST_END;
            end
          end
        end
        ST_END: begin
          // one-cycle status report
          done_q      <= 1'b1;
          chk_cond_q  <= err_q;
          sense_key_q <= err_q ? `KEY_ILLEGAL : 4'h0;
          sense_asc_q <= err_q ? asc_q : 16'h0;
          state_q     <= ST_IDLE;
        end
        default: state_q <= ST_IDLE; // stray code back to idle
      endcase
    end
  end

  // ****************************************************************
  // register writes and history store
  // ****************************************************************
  // no append past reported max, none while frozen
  wire hist_ok = !snap_q && hist_len_q < HIST_MAX;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      max_lba_q   <= 64'h0;
      blk_len_q   <= `RST_BLK_LEN;
      prot_en_q   <= 1'b0;
      prot_type_q <= 3'h0;
      blk_exp_q   <= 4'h0;
      hist_len_q  <= 16'h0;
      irq_mask_q  <= 2'h0;
      for (i = 0; i < HIST_DEPTH; i = i + 1) begin
        hist_mem[i] <= 8'h00;
      end
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `OFS_LBA_LO:  max_lba_q[31:0]  <= reg_wdata;
        `OFS_LBA_HI:  max_lba_q[63:32] <= reg_wdata;
        `OFS_BLK_LEN: blk_len_q        <= reg_wdata;
        `OFS_PROT: begin
          prot_en_q   <= reg_wdata[`PROT_EN_BIT];
          prot_type_q <= reg_wdata[`PROT_TYPE_LSB +: 3];
          blk_exp_q   <= reg_wdata[`PROT_EXP_LSB +: 4];
        end
        `OFS_HIST_WR: begin
          if (hist_ok) begin
            hist_mem[hist_len_q[5:0]] <= reg_wdata[7:0];
            hist_len_q <= hist_len_q + 16'd1;
          end
        end
        `OFS_HIST_CLR: begin
          if (!snap_q) begin
            hist_len_q <= 16'h0;
          end
        end
        `OFS_IRQ_MASK: irq_mask_q <= reg_wdata[1:0];
        default: begin end // 18h is write-one-to-clear below; other offsets hold nothing writable
      endcase
    end
  end

  // ****************************************************************
  // interrupt status, set wins over clear
  // ****************************************************************
  wire [1:0] ev  = {done_q & chk_cond_q, done_q};
  wire [1:0] w1c = (reg_wr && reg_addr == `OFS_IRQ_STAT) ?
                   reg_wdata[1:0] : 2'h0;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= 2'h0;
    end else if (ce) begin
      irq_stat_q <= (irq_stat_q & ~w1c) | ev;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // ****************************************************************
  // register reads, data in the following cycle
  // ****************************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 32'h0;
    end else if (ce) begin
      reg_rdata_q <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `OFS_LBA_LO:   reg_rdata_q <= max_lba_q[31:0];
          `OFS_LBA_HI:   reg_rdata_q <= max_lba_q[63:32];
          `OFS_BLK_LEN:  reg_rdata_q <= blk_len_q;
          `OFS_PROT:     reg_rdata_q <= {20'h0, blk_exp_q, 4'h0,
                                         prot_type_q, prot_en_q};
          `OFS_IRQ_STAT: reg_rdata_q <= {30'h0, irq_stat_q};
          `OFS_IRQ_MASK: reg_rdata_q <= {30'h0, irq_mask_q};
          `OFS_STATE:    reg_rdata_q <= {hist_len_q, 6'h0, nexus_v_q,
                                         snap_q, nexus_q};
          default:       reg_rdata_q <= 32'h0;
        endcase
      end
    end
  end
endmodule

// ---- capacity_history_reply_checker.sv ----
module capacity_history_reply_checker (
  input logic        ref_clk,
  input logic        rst_n,
  input logic        ce,
  input logic        cmd_valid,
  input logic        cmd_ready,
  input logic        din_valid_q,
  input logic [7:0]  din_data_q,
  input logic        din_last_q,
  input logic        din_ready,
  input logic        done_q,
  input logic        chk_cond_q,
  input logic [3:0]  sense_key_q,
  input logic [15:0] sense_asc_q,
  input logic        reg_rd,
  input logic [31:0] reg_rdata_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ************************************************
  // command and reply steps
  // ************************************************
  // command taken while idle
  sequence s_take;
    ce && cmd_valid && cmd_ready;
  endsequence
  // final reply byte taken by the sink
  sequence s_last_taken;
    ce && din_valid_q && din_last_q && din_ready;
  endsequence
  a_take_busy: assert property (s_take |=> !cmd_ready && !done_q)
    else $error("idle after command taken");
  a_answer_bound: assert property (
    s_take |-> ##[2:3] (din_valid_q || done_q))
    else $error("no reply byte or done after command");
  a_byte_hold: assert property (
    ce && din_valid_q && !din_ready |=>
      din_valid_q && $stable(din_data_q) && $stable(din_last_q))
    else $error("reply byte dropped before taken");
  a_last_valid: assert property (din_last_q |-> din_valid_q)
    else $error("last flag without valid byte");
  a_done_after_last: assert property (
    s_last_taken |=> !din_valid_q ##1 done_q)
    else $error("done not two cycles after last byte");
  a_done_pulse: assert property (done_q |=> !done_q && cmd_ready)
    else $error("done longer than one cycle or not idle");
  a_sense_good: assert property (
    done_q && !chk_cond_q |-> sense_key_q == 4'h0 && sense_asc_q == 16'h0)
    else $error("sense not clear on good completion");
  a_sense_err: assert property (
    done_q && chk_cond_q |-> sense_key_q == 4'h5 &&
      (sense_asc_q == 16'h2400 || sense_asc_q == 16'h2000 ||
       sense_asc_q == 16'h0016))
    else $error("bad sense on check condition");
  a_sense_hold: assert property (
    !done_q |-> $stable(sense_asc_q) && $stable(chk_cond_q))
    else $error("sense changed without done");
  a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata_q == 32'h0)
    else $error("read data outside read answer cycle");
endmodule

bind capacity_history_reply capacity_history_reply_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .din_valid_q(din_valid_q),
  .din_data_q(din_data_q), .din_last_q(din_last_q),
  .din_ready(din_ready), .done_q(done_q), .chk_cond_q(chk_cond_q),
  .sense_key_q(sense_key_q), .sense_asc_q(sense_asc_q),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

// ---- initiator_model.sv ----
module initiator_model (
  input  logic         ref_clk,
  input  logic         cmd_ready,
  input  logic         din_valid_q,
  input  logic [7:0]   din_data_q,
  input  logic         done_q,
  output logic         cmd_valid,
  output logic [127:0] cmd_cdb,
  output logic [7:0]   cmd_nexus,
  output logic         din_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx[$];  // bytes received in data-in
  logic       slow;   // sink stalls every other cycle
  initial begin
    cmd_valid = 1'b0;
    cmd_cdb = 128'h0;
    cmd_nexus = 8'h0;
    din_ready = 1'b1;
    slow = 1'b0;
  end
  // sink: collect taken bytes, toggle ready when slow
  always @(posedge ref_clk) begin
    din_ready <= slow ? ~din_ready : 1'b1;
    if (din_valid_q && din_ready) begin
      rx.push_back(din_data_q);
    end
  end
  // hold command until taken, then wait for done
  task automatic issue(input logic [127:0] cdb, input logic [7:0] nx,
                       output logic ok);
    int n;
    rx.delete();
    // block built with reserved fields zero
    cmd_cdb <= cdb;
    cmd_nexus <= nx;
    cmd_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!cmd_ready && n < 50);
    cmd_valid <= 1'b0;
    cmd_cdb <= ~cdb;  // released block shows no stale value
    ok = 1'b0;
    for (n = 0; n < 400 && !ok; n++) begin
      @(posedge ref_clk);
      ok = done_q;
    end
  endtask
endmodule

// ---- test_capacity_history_reply.sv ----
module test_capacity_history_reply;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************
  // signals and instances
  // ************************************************
  localparam logic [63:0] VEND  = 64'h6162_6364_6566_6768; // arbitrary
  localparam logic [7:0]  VER   = 8'h5a;                   // arbitrary
  localparam int          LIMIT = 20000;                   // cycle cap
  logic         ref_clk, rst_n, ce;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata;
  logic         reg_wr, reg_rd;
  wire  [31:0]  reg_rdata_q;
  wire          cmd_valid, cmd_ready, din_valid_q, din_last_q, din_ready;
  wire  [127:0] cmd_cdb;
  wire  [7:0]   cmd_nexus, din_data_q;
  wire          done_q, chk_cond_q, irq;
  wire  [3:0]   sense_key_q;
  wire  [15:0]  sense_asc_q;
  logic [7:0]   ex[$];        // expected reply bytes
  logic [127:0] bad[5];       // faulty command blocks
  logic [15:0]  asc[5];       // their sense codes
  int           checked, n_mismatch, cycles, i;
  capacity_history_reply #(.VENDOR_ID(VEND), .VERSION(VER)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_cdb(cmd_cdb), .cmd_nexus(cmd_nexus), .cmd_ready(cmd_ready),
    .din_valid_q(din_valid_q), .din_data_q(din_data_q),
    .din_last_q(din_last_q), .din_ready(din_ready), .done_q(done_q),
    .chk_cond_q(chk_cond_q), .sense_key_q(sense_key_q),
    .sense_asc_q(sense_asc_q), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .irq(irq));
  initiator_model host (
    .ref_clk(ref_clk), .cmd_ready(cmd_ready), .din_valid_q(din_valid_q),
    .din_data_q(din_data_q), .done_q(done_q), .cmd_valid(cmd_valid),
    .cmd_cdb(cmd_cdb), .cmd_nexus(cmd_nexus), .din_ready(din_ready));
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [127:0] rb(logic [7:0] id, logic [23:0] off,
                                      logic [23:0] al);
    return {8'h3c, 8'h1c, id, off, al, 56'h0};
  endfunction
  function automatic logic [127:0] c16(logic [31:0] al);
    return {8'h9e, 8'h10, 64'h0, al, 16'h0};
  endfunction
  task automatic chk(input string w, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input string w, input logic [7:0] a,
                     input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk(w, reg_rdata_q, e);
  endtask
  // push n bytes of v, most significant first
  task automatic put(input logic [63:0] v, input int n);
    for (int k = n - 1; k >= 0; k--) ex.push_back(v[8*k +: 8]);
  endtask
  task automatic cmd(input logic [127:0] c, input logic [7:0] nx);
    logic ok;
    host.issue(c, nx, ok);
    chk("command done", ok, 1'b1);
  endtask
  task automatic cmp(input string w);
    chk(w, 64'(host.rx.size()), 64'(ex.size()));
    for (int k = 0; k < ex.size() && k < host.rx.size(); k++) begin
      chk(w, host.rx[k], ex[k]);
    end
  endtask
  task automatic sense(input logic [15:0] a);
    chk("check condition", chk_cond_q, a != 16'h0);
    chk("sense key", sense_key_q, (a != 16'h0) ? 4'h5 : 4'h0);
    chk("sense code", sense_asc_q, a);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      conclude();
    end
  end
  // ************************************************
  // tests
  // ************************************************
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdc("block length", 8'h08, 32'h200);
    rdc("unmapped", 8'h40, 32'h0);
    $display("test registers done");
    wr(8'h00, 32'h1234_5678);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h1000);
    host.slow = 1'b1;
    ex = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h00, 8'h00, 8'h10, 8'h00};
    cmd({8'h25, 120'h0}, 8'h0);
    cmp("short reply");
    sense(16'h0);
    wr(8'h04, 32'ha5);
    for (i = 0; i < 4; i++) ex[i] = 8'hff;
    cmd({8'h25, 120'h0}, 8'h0);
    cmp("short clamped");
    host.slow = 1'b0;
    for (i = 0; i < 3; i++) begin
      wr(8'h0c, {20'h0, 4'(3 * i), 4'h0, 3'(i / 2), 1'(i > 0)});
      ex.delete();
      put(64'h0000_00a5_1234_5678, 8);
      put(64'h1000, 4);
      ex.push_back({4'h0, 3'(i / 2), 1'(i > 0)});
      ex.push_back({4'h0, 4'(3 * i)});
      repeat (18) ex.push_back(8'h0);
      cmd(c16(32'd32), 8'h0);
      cmp("long reply");
    end
    while (ex.size() > 5) ex.delete(ex.size() - 1);
    cmd(c16(32'd5), 8'h0);
    cmp("long cut");
    ex.delete();
    cmd(c16(32'd0), 8'h0);
    cmp("long empty");
    sense(16'h0);
    $display("test capacity done");
    for (i = 0; i < 66; i++) wr(8'h10, 32'(8'h40 + i));
    rdc("held bytes", 8'h20, 32'h0040_0000);
    ex.delete();
    put(VEND, 8);
    put(64'({VER, 8'h01}), 2);
    repeat (20) ex.push_back(8'h0);
    put(64'd41, 2);
    for (i = 0; i < 5; i++) begin
      put({(i < 4) ? 8'(i) : 8'h10, 24'h0}, 4);
      put((i < 4) ? 64'd72 : 64'd64, 4);
    end
    cmd(rb(8'h00, 24'd0, 24'd72), 8'h1);
    cmp("directory");
    ex = '{8'h42, 8'h43, 8'h44};
    cmd(rb(8'h10, 24'd2, 24'd3), 8'h1);
    cmp("history");
    bad = '{rb(8'h10, 24'd65, 24'd1), rb(8'h00, 24'd1, 24'd8),
            rb(8'h05, 24'd0, 24'd8), rb(8'hf0, 24'd0, 24'd8),
            {8'h12, 120'h0}};
    asc = '{16'h2400, 16'h2400, 16'h2400, 16'h2400, 16'h2000};
    ex.delete();
    for (i = 0; i < 5; i++) begin
      cmd(bad[i], 8'h1);
      cmp("error reply");
      sense(asc[i]);
    end
    $display("test history done");
    ex = '{8'h40};
    cmd(rb(8'h03, 24'd0, 24'd72), 8'h1);
    sense(16'h0);
    rdc("nexus state", 8'h20, 32'h0040_0301);
    cmd(rb(8'h10, 24'd0, 24'd1), 8'h2);
    sense(16'h0016);
    cmd(rb(8'h10, 24'd0, 24'd1), 8'h1);
    cmp("owner read");
    cmd(rb(8'hfe, 24'd0, 24'd0), 8'h1);
    rdc("nexus cleared", 8'h20, 32'h0040_0101);
    cmd(rb(8'hff, 24'd0, 24'd0), 8'h1);
    rdc("released", 8'h20, 32'h0040_0001);
    $display("test nexus done");
    chk("irq masked", irq, 1'b0);
    wr(8'h1c, 32'h3);
    chk("irq raised", irq, 1'b1);
    rdc("status set", 8'h18, 32'h3);
    wr(8'h18, 32'h3);
    chk("irq cleared", irq, 1'b0);
    rdc("status", 8'h18, 32'h0);
    ce <= 1'b0;
    wr(8'h08, 32'h55);
    ce <= 1'b1;
    rdc("frozen", 8'h08, 32'h1000);
    $display("test interrupt done");
    conclude();
  end
endmodule
